/* temp_limit_register_bank.sv */
// temperature limit register bank: fraction limits, locked result pairs,
// overheat limits and hysteresis behind the two-wire pointer
// assumes the slave front end gives one-cycle read and write strobes
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R1] Bits 7..4 at the remote high alarm fraction byte are writable, 1/16 degree steps.
// [R2] Bits 7..4 at the remote low alarm fraction byte are writable, 1/16 degree steps.
// [R3] The two alarm fraction bytes sit at pointer 13h and 14h for both read and write.
// [R4] The local result low byte at 15h is read-only, fraction in its upper nibble.
// [R5] Each local conversion rewrites the local low byte unless a paired read holds it.
// [R6] Reading a high result byte holds its low byte until that low byte is read.
// [R7] Reading a low result byte first holds its high byte until that is read.
// [R8] Reading any register other than the partner byte releases the hold; the code keeps it on a repeat read of the byte that set it.
// [R9] The host should read the high byte first and the low byte in the next read.
// [R10] The host may skip the low byte when only the integer part is needed.
// [R11] Remote overheat limit at 19h is read/write, 1 degree steps, reset 6Ch.
// [R12] Local overheat limit at 20h is read/write, 1 degree steps, reset 55h.
// [R13] Overheat hysteresis at 21h is read/write and resets to 0Ah.
// [R14] Shutdown releases only once the reading falls hysteresis degrees below the limit.
// [R15] The remote result pair follows the same hold rules as the local one.
// [R16] Shutdown asserts when a reading reaches its channel's overheat limit.
// [R17] Alarm limits join the integer byte and fraction nibble into twelve bits.
module temp_limit_register_bank (
  // clock and reset
  input  wire logic                  I_CLK,
  input  wire logic                  I_SRST,
  // pointer register access
  input  wire logic [7:0]            I_REG_PTR,
  input  wire logic                  I_REG_WR,
  input  wire logic [7:0]            I_REG_WDATA,
  input  wire logic                  I_REG_RD,
  output logic      [7:0]            O_REG_RDATA,
  output logic                       O_REG_RVALID,
  // converter results
  input  wire logic                  I_LOCAL_DONE,
  input  wire temp_limit_pkg::temp_t I_LOCAL_RESULT,
  input  wire logic                  I_REMOTE_DONE,
  input  wire temp_limit_pkg::temp_t I_REMOTE_RESULT,
  // integer alarm limit bytes held outside
  input  wire logic [7:0]            I_REMOTE_HIGH_LIMIT_INT,
  input  wire logic [7:0]            I_REMOTE_LOW_LIMIT_INT,
  // comparator outputs
  output logic                       O_REMOTE_HIGH_ALARM,
  output logic                       O_REMOTE_LOW_ALARM,
  output logic                       O_OVERHEAT_SHUTDOWN
);
  import temp_limit_pkg::*;

  logic [3:0] rh_frac_q;
  logic [3:0] rl_frac_q;
  logic [7:0] r_ovh_q;
  logic [7:0] l_ovh_q;
  logic [7:0] hys_q;
  logic [7:0] rd_mux;
  logic       done     [N_CH];
  temp_t      res      [N_CH];
  temp_t      meas_w   [N_CH];
  logic [7:0] ovh_lim  [N_CH];
  logic [7:0] hi_b     [N_CH];
  logic [3:0] lo_n     [N_CH];
  logic       lo_held  [N_CH];
  logic       hi_held  [N_CH];
  logic [N_CH-1:0] ovh_act;
  temp_t      high_lim;
  temp_t      low_lim;

  assign done[CH_LOCAL]     = I_LOCAL_DONE;
  assign done[CH_REMOTE]    = I_REMOTE_DONE;
  assign res[CH_LOCAL]      = I_LOCAL_RESULT;
  assign res[CH_REMOTE]     = I_REMOTE_RESULT;
  assign ovh_lim[CH_LOCAL]  = l_ovh_q;
  assign ovh_lim[CH_REMOTE] = r_ovh_q;

  // per channel: locked result pair, live measurement, overheat flag
  for (genvar c = 0; c < N_CH; c++)
  begin : g_ch
    pair_if pif ();
    temp_t  meas_q;

    assign pif.conv_done  = done[c];
    assign pif.conv_value = res[c];
    assign pif.rd_high    = I_REG_RD && (I_REG_PTR == ADDR_HIGH[c]); // see R9
    assign pif.rd_low     = I_REG_RD && (I_REG_PTR == ADDR_LOW[c]);
    // an unread low byte stays held only until the next other read
    assign pif.rd_other   = I_REG_RD && !pif.rd_high && !pif.rd_low; // see R8, see R10

    result_pair_lock u_lock ( // see R15
      .i_clk  (I_CLK),
      .i_srst (I_SRST),
      .p      (pif.owner)
    );

    assign hi_b[c]    = pif.high_byte;
    assign lo_n[c]    = pif.low_nib;
    assign lo_held[c] = pif.low_held;
    assign hi_held[c] = pif.high_held;

    // comparators see every conversion, locked or not
    always_ff @(posedge I_CLK)
    begin
      if (I_SRST)
        meas_q <= RST_RESULT;
      else if (done[c])
        meas_q <= res[c];
    end
    assign meas_w[c] = meas_q;

    overheat_hysteresis u_ovh (
      .i_clk    (I_CLK),
      .i_srst   (I_SRST),
      .i_meas   (meas_q),
      .i_limit  (ovh_lim[c]), // see R11, see R12
      .i_hys    (hys_q),      // see R14
      .o_active (ovh_act[c])
    );
  end

  // alarm fraction limits; low nibble is reserved and not stored
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      rh_frac_q <= RST_FRAC[FRAC_MSB:FRAC_LSB];
      rl_frac_q <= RST_FRAC[FRAC_MSB:FRAC_LSB];
    end
    else if (I_REG_WR)
    begin
      if (I_REG_PTR == ADDR_RH_FRAC)
        rh_frac_q <= I_REG_WDATA[FRAC_MSB:FRAC_LSB]; // see R1, see R3
      if (I_REG_PTR == ADDR_RL_FRAC)
        rl_frac_q <= I_REG_WDATA[FRAC_MSB:FRAC_LSB]; // see R2, see R3
    end
  end

  // overheat limits and hysteresis; writes to result bytes fall through
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      r_ovh_q <= RST_R_OVH; // see R11
      l_ovh_q <= RST_L_OVH; // see R12
      hys_q   <= RST_HYS;   // see R13
    end
    else if (I_REG_WR)
    begin
      if (I_REG_PTR == ADDR_R_OVH)
        r_ovh_q <= I_REG_WDATA; // see R11
      if (I_REG_PTR == ADDR_L_OVH)
        l_ovh_q <= I_REG_WDATA; // see R12
      if (I_REG_PTR == ADDR_HYS)
        hys_q <= I_REG_WDATA;   // see R13
    end
  end

  always_comb
  begin
    case (I_REG_PTR)
      ADDR_LOCAL_HIGH:  rd_mux = hi_b[CH_LOCAL];
      ADDR_REMOTE_HIGH: rd_mux = hi_b[CH_REMOTE];
      ADDR_REMOTE_LOW:  rd_mux = {lo_n[CH_REMOTE], 4'h0};
      ADDR_RH_FRAC:     rd_mux = {rh_frac_q, 4'h0}; // see R3
      ADDR_RL_FRAC:     rd_mux = {rl_frac_q, 4'h0}; // see R3
      ADDR_LOCAL_LOW:   rd_mux = {lo_n[CH_LOCAL], 4'h0}; // see R4
      ADDR_R_OVH:       rd_mux = r_ovh_q;
      ADDR_L_OVH:       rd_mux = l_ovh_q;
      ADDR_HYS:         rd_mux = hys_q;
      default:          rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_REG_RVALID <= 1'b0;
      O_REG_RDATA  <= 8'h00;
    end
    else
    begin
      O_REG_RVALID <= I_REG_RD;
      if (I_REG_RD)
        O_REG_RDATA <= rd_mux;
    end
  end

  assign high_lim = {I_REMOTE_HIGH_LIMIT_INT, rh_frac_q}; // see R17
  assign low_lim  = {I_REMOTE_LOW_LIMIT_INT, rl_frac_q};  // see R17

  // outputs registered once more so every pin leaves a flop
  always_ff @(posedge I_CLK)
  begin
    if (I_SRST)
    begin
      O_REMOTE_HIGH_ALARM <= 1'b0;
      O_REMOTE_LOW_ALARM  <= 1'b0;
      O_OVERHEAT_SHUTDOWN <= 1'b0;
    end
    else
    begin
      O_REMOTE_HIGH_ALARM <= meas_w[CH_REMOTE] > high_lim; // see R1, see R17
      O_REMOTE_LOW_ALARM  <= meas_w[CH_REMOTE] < low_lim;  // see R2, see R17
      O_OVERHEAT_SHUTDOWN <= |ovh_act;                     // see R16
    end
  end

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_SRST);

  sequence s_local_high_read;
    I_REG_RD && (I_REG_PTR == ADDR_LOCAL_HIGH);
  endsequence
  sequence s_local_low_read;
    I_REG_RD && (I_REG_PTR == ADDR_LOCAL_LOW);
  endsequence
  sequence s_remote_high_read;
    I_REG_RD && (I_REG_PTR == ADDR_REMOTE_HIGH);
  endsequence
  sequence s_remote_low_read;
    I_REG_RD && (I_REG_PTR == ADDR_REMOTE_LOW);
  endsequence
  sequence s_quiet_two;
    (!I_REG_RD)[*2];
  endsequence

  chk_high_frac_store: // see R1
    assert property (I_REG_WR && (I_REG_PTR == ADDR_RH_FRAC)
      |=> rh_frac_q == $past(I_REG_WDATA[7:4]))
    else $error("high alarm fraction not stored");

  chk_low_frac_store: // see R2
    assert property (I_REG_WR && (I_REG_PTR == ADDR_RL_FRAC)
      |=> rl_frac_q == $past(I_REG_WDATA[7:4]))
    else $error("low alarm fraction not stored");

  chk_frac_read_back: // see R3
    assert property (I_REG_RD && (I_REG_PTR == ADDR_RL_FRAC)
      |=> O_REG_RVALID && (O_REG_RDATA == {$past(rl_frac_q), 4'h0}))
    else $error("low alarm fraction read back wrong");

  chk_local_low_ro: // see R4
    assert property (I_REG_WR && (I_REG_PTR == ADDR_LOCAL_LOW) && !I_LOCAL_DONE
      |=> $stable(lo_n[CH_LOCAL]))
    else $error("local low byte changed by a write");

  chk_local_low_update: // see R5
    assert property (I_LOCAL_DONE && !lo_held[CH_LOCAL]
      && !(I_REG_RD && (I_REG_PTR == ADDR_LOCAL_HIGH))
      |=> lo_n[CH_LOCAL] == $past(I_LOCAL_RESULT[3:0]))
    else $error("local low byte missed a conversion");

  chk_low_byte_held: // see R6
    assert property (s_local_high_read ##1 s_quiet_two |=> $stable(lo_n[CH_LOCAL]))
    else $error("local low byte changed while held");

  chk_high_byte_held: // see R7
    assert property (s_local_low_read ##1 s_quiet_two |=> $stable(hi_b[CH_LOCAL]))
    else $error("local high byte changed while held");

  chk_lock_release: // see R8
    assert property ((lo_held[CH_LOCAL] || hi_held[CH_LOCAL]) && I_REG_RD
      && (I_REG_PTR != ADDR_LOCAL_HIGH) && (I_REG_PTR != ADDR_LOCAL_LOW)
      |=> !lo_held[CH_LOCAL] && !hi_held[CH_LOCAL])
    else $error("hold not released by another read");

  chk_remote_pair_held: // see R15
    assert property (s_remote_high_read ##1 s_quiet_two |=> $stable(lo_n[CH_REMOTE]))
    else $error("remote low byte changed while held");

  chk_limit_reset: // see R11, see R12, see R13
    assert property ($fell(I_SRST) |-> (r_ovh_q == RST_R_OVH) && (l_ovh_q == RST_L_OVH)
      && (hys_q == RST_HYS))
    else $error("overheat limits wrong after reset");

  chk_alarm_join: // see R17
    assert property (!$past(I_SRST) |-> O_REMOTE_HIGH_ALARM
      == $past(meas_w[CH_REMOTE] > {I_REMOTE_HIGH_LIMIT_INT, rh_frac_q}))
    else $error("high alarm not from joined limit");

  chk_shutdown_follow: // see R16
    assert property (!$past(I_SRST) |-> O_OVERHEAT_SHUTDOWN == $past(|ovh_act))
    else $error("shutdown output does not follow channel flags");

  chk_remote_high_held: // see R15
    assert property (s_remote_low_read ##1 s_quiet_two |=> $stable(hi_b[CH_REMOTE]))
    else $error("remote high byte changed while held");

  chk_remote_low_update: // see R15
    assert property (I_REMOTE_DONE && !lo_held[CH_REMOTE]
      && !(I_REG_RD && (I_REG_PTR == ADDR_REMOTE_HIGH))
      |=> lo_n[CH_REMOTE] == $past(I_REMOTE_RESULT[3:0]))
    else $error("remote low byte missed a conversion");

  chk_remote_ovh_store: // see R11
    assert property (I_REG_WR && (I_REG_PTR == ADDR_R_OVH)
      |=> r_ovh_q == $past(I_REG_WDATA))
    else $error("remote overheat limit not stored");

  chk_local_ovh_store: // see R12
    assert property (I_REG_WR && (I_REG_PTR == ADDR_L_OVH)
      |=> l_ovh_q == $past(I_REG_WDATA))
    else $error("local overheat limit not stored");

  chk_hys_store: // see R13
    assert property (I_REG_WR && (I_REG_PTR == ADDR_HYS)
      |=> hys_q == $past(I_REG_WDATA))
    else $error("hysteresis not stored");

  chk_low_alarm_join: // see R2, see R17
    assert property (!$past(I_SRST) |-> O_REMOTE_LOW_ALARM
      == $past(meas_w[CH_REMOTE] < {I_REMOTE_LOW_LIMIT_INT, rl_frac_q}))
    else $error("low alarm not from joined limit");

  chk_read_valid: // see R3
    assert property (!$past(I_SRST) |-> O_REG_RVALID == $past(I_REG_RD))
    else $error("read valid not one cycle after the read");
endmodule
`default_nettype wire

/* temp_limit_pkg.sv */
// constants, types and pointer map for the temperature limit register bank
// assumes an 8-bit register pointer set by the two-wire slave front end
`default_nettype none
package temp_limit_pkg;
  // pointer addresses
  localparam logic [7:0] ADDR_LOCAL_HIGH  = 8'h00;
  localparam logic [7:0] ADDR_REMOTE_HIGH = 8'h01;
  localparam logic [7:0] ADDR_REMOTE_LOW  = 8'h10;
  localparam logic [7:0] ADDR_RH_FRAC     = 8'h13;
  localparam logic [7:0] ADDR_RL_FRAC     = 8'h14;
  localparam logic [7:0] ADDR_LOCAL_LOW   = 8'h15;
  localparam logic [7:0] ADDR_R_OVH       = 8'h19;
  localparam logic [7:0] ADDR_L_OVH       = 8'h20;
  localparam logic [7:0] ADDR_HYS         = 8'h21;
  // reset values
  localparam logic [7:0]  RST_FRAC   = 8'h00;
  localparam logic [7:0]  RST_R_OVH  = 8'h6C;
  localparam logic [7:0]  RST_L_OVH  = 8'h55;
  localparam logic [7:0]  RST_HYS    = 8'h0A;
  localparam logic [11:0] RST_RESULT = 12'h000;
  // fraction field sits in bits 7..4 of a low byte
  localparam int FRAC_MSB = 7;
  localparam int FRAC_LSB = 4;
  // channels
  localparam int N_CH      = 2;
  localparam int CH_LOCAL  = 0;
  localparam int CH_REMOTE = 1;
  localparam logic [7:0] ADDR_HIGH [N_CH] = '{ADDR_LOCAL_HIGH, ADDR_REMOTE_HIGH};
  localparam logic [7:0] ADDR_LOW  [N_CH] = '{ADDR_LOCAL_LOW, ADDR_REMOTE_LOW};

  // twelve-bit temperature: integer byte then fraction nibble
  typedef logic [11:0] temp_t;
  typedef enum logic [1:0] {LK_OPEN, LK_LOW_HELD, LK_HIGH_HELD} lock_state_t;
endpackage
`default_nettype wire

/* pair_if.sv */
// byte-pair result carrier between the bank and one lock keeper
// assumes read strobes are single-cycle pulses from the register front end
`timescale 1ns/1ps
`default_nettype none
interface pair_if;
  logic                  conv_done;
  temp_limit_pkg::temp_t conv_value;
  logic                  rd_high;
  logic                  rd_low;
  logic                  rd_other;
  logic [7:0]            high_byte;
  logic [3:0]            low_nib;
  logic                  low_held;
  logic                  high_held;

  modport owner (
    input  conv_done, conv_value, rd_high, rd_low, rd_other,
    output high_byte, low_nib, low_held, high_held
  );
  modport user (
    output conv_done, conv_value, rd_high, rd_low, rd_other,
    input  high_byte, low_nib, low_held, high_held
  );
endinterface
`default_nettype wire

/* result_pair_lock.sv */
// result byte pair of one channel with read-order locking
// assumes conv_done is a one-cycle pulse from the converter
`timescale 1ns/1ps
`default_nettype none
module result_pair_lock (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_srst,
  // result pair
  pair_if.owner     p
);
  import temp_limit_pkg::*;

  lock_state_t st_q;
  lock_state_t st_d;
  logic [7:0]  high_q;
  logic [3:0]  low_q;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      LK_OPEN:
      begin
        if (p.rd_high)
          st_d = LK_LOW_HELD;
        else if (p.rd_low)
          st_d = LK_HIGH_HELD;
      end
      LK_LOW_HELD:
      begin
        if (p.rd_low || p.rd_other)
          st_d = LK_OPEN;
      end
      LK_HIGH_HELD:
      begin
        if (p.rd_high || p.rd_other)
          st_d = LK_OPEN;
      end
      default:
        st_d = LK_OPEN;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      st_q <= LK_OPEN;
    else
      st_q <= st_d; // see R6, see R7, see R8
  end

  // the partner of the byte being read is frozen that cycle too, so a
  // conversion landing on the read edge cannot split the pair
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      high_q <= RST_RESULT[11:4];
    else if (p.conv_done && st_q != LK_HIGH_HELD && !p.rd_low)
      high_q <= p.conv_value[11:4]; // see R7
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      low_q <= RST_RESULT[3:0];
    else if (p.conv_done && st_q != LK_LOW_HELD && !p.rd_high)
      low_q <= p.conv_value[3:0]; // see R5, see R6
  end

  assign p.high_byte = high_q;
  assign p.low_nib   = low_q;
  assign p.low_held  = (st_q == LK_LOW_HELD);
  assign p.high_held = (st_q == LK_HIGH_HELD);
endmodule
`default_nettype wire

/* overheat_hysteresis.sv */
// overheat shutdown flag of one channel with hysteresis release
// assumes the limits are unsigned whole-degree bytes and the measurement an unsigned twelve-bit value
`timescale 1ns/1ps
`default_nettype none
module overheat_hysteresis (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_srst,
  // comparison inputs
  input  wire temp_limit_pkg::temp_t i_meas,
  input  wire logic [7:0]            i_limit,
  input  wire logic [7:0]            i_hys,
  // flag
  output logic                       o_active
);
  import temp_limit_pkg::*;

  logic [8:0] thr;
  logic       trip;
  logic       clear;

  assign thr   = {1'b0, i_limit} - {1'b0, i_hys};
  assign trip  = i_meas[11:4] >= i_limit; // see R16
  // hysteresis above the limit leaves the flag latched until reset
  assign clear = !thr[8] && (i_meas < {thr[7:0], 4'h0}); // see R14

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_active <= 1'b0;
    else if (trip)
      o_active <= 1'b1; // see R16
    else if (clear)
      o_active <= 1'b0; // see R14
  end

  chk_overheat_trip: // see R16
    assert property (@(posedge i_clk) disable iff (i_srst)
      (i_meas[11:4] >= i_limit) |=> o_active)
    else $error("overheat flag not set at limit");

  chk_overheat_release: // see R14
    assert property (@(posedge i_clk) disable iff (i_srst)
      (i_meas[11:4] < i_limit) && (i_limit >= i_hys)
        && (i_meas < {i_limit - i_hys, 4'h0}) |=> !o_active)
    else $error("overheat flag not released below hysteresis");
endmodule
`default_nettype wire

/* host_model.sv */
// two-wire host stand-in driving the pointer register strobes
// assumes one clock shared with the bank; the caller sequences all requests
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input  wire logic       i_clk,
  // pointer register access
  output logic      [7:0] o_ptr,
  output logic            o_wr,
  output logic      [7:0] o_wdata,
  output logic            o_rd,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid
);
  initial
  begin
    o_ptr = 8'h5A;
    o_wr = 1'b0;
    o_wdata = 8'hA5;
    o_rd = 1'b0;
  end

  // idle cycles before a request make the host slow on demand
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    #2;
    o_ptr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk);
    #2;
    o_wr = 1'b0;
    // released lines never keep their last value
    o_ptr = ~a;
    o_wdata = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, input int gap, output logic [7:0] d,
                          output logic ok);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    #2;
    o_ptr = a;
    o_rd = 1'b1;
    @(posedge i_clk);
    #2;
    o_rd = 1'b0;
    o_ptr = ~a;
    // valid stands one cycle only, so it is taken here
    ok = i_rvalid;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

/* temp_limit_register_bank_bench.sv */
// self-checking bench for the temperature limit register bank
// assumes host_model owns the pointer bus; converter pulses come from here
`timescale 1ns/1ps
`default_nettype none
module temp_limit_register_bank_bench;
  import temp_limit_pkg::*;
  logic        clk;
  logic        srst;
  logic [7:0]  ptr;
  logic        wr;
  logic [7:0]  wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        l_done;
  temp_t       l_res;
  logic        r_done;
  temp_t       r_res;
  logic [7:0]  hi_int;
  logic [7:0]  lo_int;
  logic        hi_alarm;
  logic        lo_alarm;
  logic        shutdown;
  int          n_fail;
  int          cmp_count;
  // model: lk 0 open, 1 low byte held, 2 high byte held
  int          regs [int];
  int          hi_m [2];
  int          lo_m [2];
  int          lk   [2];
  int          meas [2];
  int          oh   [2];
  logic [7:0]  probe [10] = '{8'h13, 8'h14, 8'h15, 8'h19, 8'h20, 8'h21, 8'h00, 8'h01,
                              8'h10, 8'h3A};

  host_model u_host (
    .i_clk    (clk),
    .o_ptr    (ptr),
    .o_wr     (wr),
    .o_wdata  (wdata),
    .o_rd     (rd),
    .i_rdata  (rdata),
    .i_rvalid (rvalid)
  );

  temp_limit_register_bank u_dut (
    .I_CLK                   (clk),
    .I_SRST                  (srst),
    .I_REG_PTR               (ptr),
    .I_REG_WR                (wr),
    .I_REG_WDATA             (wdata),
    .I_REG_RD                (rd),
    .O_REG_RDATA             (rdata),
    .O_REG_RVALID            (rvalid),
    .I_LOCAL_DONE            (l_done),
    .I_LOCAL_RESULT          (l_res),
    .I_REMOTE_DONE           (r_done),
    .I_REMOTE_RESULT         (r_res),
    .I_REMOTE_HIGH_LIMIT_INT (hi_int),
    .I_REMOTE_LOW_LIMIT_INT  (lo_int),
    .O_REMOTE_HIGH_ALARM     (hi_alarm),
    .O_REMOTE_LOW_ALARM      (lo_alarm),
    .O_OVERHEAT_SHUTDOWN     (shutdown)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // flags are re-judged at every event that can move them
  function automatic void oh_eval();
    int lim;
    for (int ch = 0; ch < N_CH; ch++)
    begin
      lim = (ch == CH_REMOTE) ? regs[ADDR_R_OVH] : regs[ADDR_L_OVH];
      if ((meas[ch] >> 4) >= lim)
        oh[ch] = 1;
      else if (meas[ch] < (lim - regs[ADDR_HYS]) * 16)
        oh[ch] = 0;
    end
  endfunction

  function automatic int model_read(int a);
    int e;
    e = regs.exists(a) ? regs[a] : 0;
    for (int ch = 0; ch < N_CH; ch++)
    begin
      if (a == ADDR_HIGH[ch])
      begin
        e = hi_m[ch];
        lk[ch] = (lk[ch] == 2) ? 0 : 1;
      end
      else if (a == ADDR_LOW[ch])
      begin
        e = lo_m[ch] << 4;
        lk[ch] = (lk[ch] == 1) ? 0 : 2;
      end
      else
        lk[ch] = 0;
    end
    return e;
  endfunction

  function automatic logic [11:0] rnd12();
    return 12'($urandom_range(0, 12'h6FF));
  endfunction

  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] d;
    logic       ok;
    u_host.read_reg(a, $urandom_range(0, 2), d, ok);
    check({11'h000, ok}, 12'h001);
    check({4'h0, d}, 12'(model_read(a)));
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d, $urandom_range(0, 2));
    if (a == ADDR_RH_FRAC || a == ADDR_RL_FRAC)
      regs[a] = d & 8'hF0;
    else if (regs.exists(a))
      regs[a] = d;
    oh_eval();
  endtask

  // one conversion, then the comparator outputs once all flops have moved
  task automatic conv(input int ch, input logic [11:0] v);
    int hl;
    int ll;
    @(posedge clk);
    #2;
    if (ch == CH_LOCAL)
    begin
      l_done = 1'b1;
      l_res = v;
    end
    else
    begin
      r_done = 1'b1;
      r_res = v;
    end
    @(posedge clk);
    #2;
    l_done = 1'b0;
    r_done = 1'b0;
    l_res = ~l_res;
    r_res = ~r_res;
    if (lk[ch] != 1)
      lo_m[ch] = v[3:0];
    if (lk[ch] != 2)
      hi_m[ch] = v[11:4];
    meas[ch] = v;
    oh_eval();
    repeat (2) @(posedge clk);
    #2;
    hl = hi_int * 16 + (regs[ADDR_RH_FRAC] >> 4);
    ll = lo_int * 16 + (regs[ADDR_RL_FRAC] >> 4);
    check({11'h000, hi_alarm}, 12'(meas[CH_REMOTE] > hl));
    check({11'h000, lo_alarm}, 12'(meas[CH_REMOTE] < ll));
    check({11'h000, shutdown}, 12'(oh[0] | oh[1]));
  endtask

  initial
  begin
    #(50 * 6000);
    n_fail++;
    close_out();
  end

  initial
  begin
    logic [11:0] v;
    void'($urandom(50933));
    srst = 1'b1;
    l_done = 1'b0;
    r_done = 1'b0;
    l_res = 12'h000;
    r_res = 12'h000;
    hi_int = 8'h00;
    lo_int = 8'h00;
    regs[ADDR_RH_FRAC] = 8'h00;
    regs[ADDR_RL_FRAC] = 8'h00;
    regs[ADDR_R_OVH] = 8'h6C;
    regs[ADDR_L_OVH] = 8'h55;
    regs[ADDR_HYS] = 8'h0A;
    repeat (5) @(posedge clk);
    #2;
    srst = 1'b0;
    foreach (probe[i]) rd_chk(probe[i]);
    foreach (probe[i]) wr_reg(probe[i], 8'($urandom));
    foreach (probe[i]) rd_chk(probe[i]);
    wr_reg(ADDR_R_OVH, 8'h70);
    wr_reg(ADDR_L_OVH, 8'h30);
    wr_reg(ADDR_HYS, 8'h05);
    for (int ch = 0; ch < N_CH; ch++)
    begin
      conv(ch, rnd12());
      rd_chk(ADDR_HIGH[ch]);
      conv(ch, rnd12());
      rd_chk(ADDR_LOW[ch]);
      rd_chk(ADDR_LOW[ch]);
      conv(ch, rnd12());
      rd_chk(ADDR_HIGH[ch]);
      rd_chk(ADDR_HIGH[ch]);
      conv(ch, rnd12());
      rd_chk(ADDR_HYS);
      conv(ch, rnd12());
      rd_chk(ADDR_LOW[ch]);
    end
    for (int i = 0; i < 6; i++)
    begin
      hi_int = 8'($urandom_range(8'h10, 8'h60));
      lo_int = 8'($urandom_range(8'h00, 8'h30));
      wr_reg(ADDR_RH_FRAC, 8'($urandom));
      wr_reg(ADDR_RL_FRAC, 8'($urandom));
      // first two runs sit exactly on a limit, where strict compares stay quiet
      v = (i == 0) ? {hi_int, 4'(regs[ADDR_RH_FRAC] >> 4)} :
          (i == 1) ? {lo_int, 4'(regs[ADDR_RL_FRAC] >> 4)} : rnd12();
      conv(CH_REMOTE, v);
    end
    conv(CH_LOCAL, 12'h300);
    conv(CH_LOCAL, 12'h2B0);
    conv(CH_LOCAL, 12'h2AF);
    conv(CH_REMOTE, 12'h700);
    wr_reg(ADDR_HYS, 8'h00);
    conv(CH_REMOTE, 12'h6FF);
    close_out();
  end
endmodule
`default_nettype wire
